// *** pkg/op_pkg.sv ***
// Opcode encodings, field positions and reset values for the four operations
package op_pkg;
  localparam int          INSN_W        = 14;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam int          DEST_BIT      = 7;
  localparam int          ADDR_LSB      = 0;
  localparam int          LIT_LSB       = 0;
  localparam int          OPC_HI        = 13;
  localparam int          OPC_LO        = 8;
  localparam logic [5:0]  NIBBLE_OPC    = 6'h0E;
  localparam logic [5:0]  RXOR_OPC      = 6'h06;
  localparam logic [5:0]  LXOR_OPC      = 6'h1F;
  localparam logic [5:0]  ZCHK_OPC      = 6'h08;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic        ZERO_RESET    = 1'b0;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_NIBBLE = 3'b001,
    OP_ZCHK   = 3'b010,
    OP_LXOR   = 3'b011,
    OP_RXOR   = 3'b100
  } op_type;
endpackage : op_pkg

// *** verilog/op_decode.sv ***
// Instruction word decoder for the four operations
`timescale 1ns/1ps
module op_decode (
  input  wire logic [13:0]    insn,
  output op_pkg::op_type      op
);
  always_comb begin
    if (insn[op_pkg::OPC_HI:op_pkg::OPC_LO] == op_pkg::NIBBLE_OPC) begin
      op = op_pkg::OP_NIBBLE;
    end else if (insn[op_pkg::OPC_HI:op_pkg::OPC_LO] == op_pkg::RXOR_OPC) begin
      op = op_pkg::OP_RXOR;
    end else if (insn[op_pkg::OPC_HI:op_pkg::OPC_LO] == op_pkg::LXOR_OPC) begin
      op = op_pkg::OP_LXOR;
    end else if (insn[op_pkg::OPC_HI:op_pkg::OPC_LO] == op_pkg::ZCHK_OPC &&
                 insn[op_pkg::DEST_BIT]) begin
      op = op_pkg::OP_ZCHK;
    end else begin
      op = op_pkg::OP_NONE;
    end
  end
endmodule : op_decode

// *** verilog/nibble_swap_xor_test_ops.sv ***
// Execute stage for nibble exchange, zero check and the two XOR operations
//
// Contract
// - Nibble exchange swaps the source nibbles and leaves every flag.
// - Nibble exchange writes the accumulator on d 0, the register on d 1.
// - Literal XOR loads accumulator XOR literal and updates zero.
// - Register XOR updates zero and loads the accumulator on d 0.
// - Register XOR on d 1 writes the register, accumulator untouched.
`timescale 1ns/1ps
module nibble_swap_xor_test_ops (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        insn_valid,
  input  wire logic [13:0] insn,
  input  wire logic [7:0]  file_rdata,
  output logic [6:0]       file_addr,
  output logic [7:0]       file_wdata,
  output logic             file_we,
  output logic [7:0]       acc,
  output logic             zero_flag,
  output logic             done
);
  op_pkg::op_type op;
  logic [7:0]     acc_ff;
  logic [7:0]     nxt_acc;
  logic           zero_ff;
  logic           nxt_zero;
  logic [6:0]     addr_ff;
  logic [6:0]     nxt_addr;
  logic [7:0]     wdata_ff;
  logic [7:0]     nxt_wdata;
  logic           we_ff;
  logic           nxt_we;
  logic           done_ff;
  logic           nxt_done;
  logic [7:0]     swapped;
  logic [7:0]     lxor_val;
  logic [7:0]     rxor_val;
  logic           dest;
  logic [7:0]     lit;

  // All-zero test shared by every flag update
  function automatic logic is_zero(input logic [7:0] val);
    is_zero = val == 8'h00;
  endfunction : is_zero

  // Operations whose result may go back to the file register
  function automatic logic has_dest(input op_pkg::op_type kind);
    has_dest = kind == op_pkg::OP_NIBBLE || kind == op_pkg::OP_RXOR;
  endfunction : has_dest

  op_decode u_dec (
    .insn (insn),
    .op   (op)
  );

  // Instruction fields
  assign dest = insn[op_pkg::DEST_BIT];
  assign lit  = insn[op_pkg::LIT_LSB +: op_pkg::DATA_W];

  // Nibble exchange, one bit pair per step
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_swap
      assign swapped[g]     = file_rdata[g + 4];
      assign swapped[g + 4] = file_rdata[g];
    end
  endgenerate

  // Both XOR results exist every cycle; the decoded case picks one
  assign lxor_val = acc_ff ^ lit;
  assign rxor_val = acc_ff ^ file_rdata;

  // Accumulator and zero flag
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_zero = zero_ff;
    if (insn_valid) begin
      case (op)
        op_pkg::OP_NIBBLE: begin
          // Zero flag is left alone here
          if (!dest) begin
            nxt_acc = swapped;
          end
        end
        op_pkg::OP_ZCHK: begin
          // Accumulator is left alone here
          nxt_zero = is_zero(file_rdata);
        end
        op_pkg::OP_LXOR: begin
          nxt_acc  = lxor_val;
          nxt_zero = is_zero(lxor_val);
        end
        op_pkg::OP_RXOR: begin
          nxt_zero = is_zero(rxor_val);
          // With d set the accumulator keeps its value
          if (!dest) begin
            nxt_acc = rxor_val;
          end
        end
        default: begin
          nxt_acc  = acc_ff;
          nxt_zero = zero_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff  <= op_pkg::ACC_RESET;
      zero_ff <= op_pkg::ZERO_RESET;
    end else begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // File register write port; the address always follows the word
  always_comb begin
    nxt_addr  = insn[op_pkg::ADDR_LSB +: op_pkg::ADDR_W];
    nxt_wdata = wdata_ff;
    nxt_we    = 1'b0;
    if (insn_valid && has_dest(op) && dest) begin
      case (op)
        op_pkg::OP_NIBBLE: begin
          nxt_wdata = swapped;
          nxt_we    = 1'b1;
        end
        op_pkg::OP_RXOR: begin
          nxt_wdata = rxor_val;
          nxt_we    = 1'b1;
        end
        default: begin
          nxt_wdata = wdata_ff;
          nxt_we    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff  <= 7'h00;
      wdata_ff <= 8'h00;
      we_ff    <= 1'b0;
    end else begin
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff    <= nxt_we;
    end
  end

  // Completion pulse, one cycle after any decoded word
  always_comb begin
    nxt_done = 1'b0;
    if (insn_valid) begin
      case (op)
        op_pkg::OP_NONE: begin
          nxt_done = 1'b0;
        end
        default: begin
          nxt_done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  // Every output is a plain register copy

  assign acc        = acc_ff;
  assign zero_flag  = zero_ff;
  assign file_addr  = addr_ff;
  assign file_wdata = wdata_ff;
  assign file_we    = we_ff;
  assign done       = done_ff;
endmodule : nibble_swap_xor_test_ops

// *** tb/ops_props.sv ***
// Assertions on the operation unit ports
`timescale 1ns/1ps
module ops_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0]  file_rdata,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  input wire logic [7:0]  acc,
  input wire logic        zero_flag,
  input wire logic        done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [5:0] oc = insn[13:8];
  wire d = insn[7];
  wire nb = insn_valid && oc == op_pkg::NIBBLE_OPC;
  wire rx = insn_valid && oc == op_pkg::RXOR_OPC;
  wire lx = insn_valid && oc == op_pkg::LXOR_OPC;
  wire zc = insn_valid && oc == op_pkg::ZCHK_OPC && d;
  wire [7:0] sw = {file_rdata[3:0], file_rdata[7:4]};
  wire [7:0] r = acc ^ file_rdata;
  swap_wb_a: assert property (nb && d |=> file_we &&
    file_wdata == $past(sw) && $stable(zero_flag)) else $error("swap wb");
  swap_acc_a: assert property (nb && !d |=> acc == $past(sw) &&
    !file_we && $stable(zero_flag) && done) else $error("swap acc");
  zc_set_a: assert property (zc && file_rdata == 8'h00 |=> zero_flag)
    else $error("zc set");
  lit_xor_a: assert property (lx |=> acc == $past(acc ^ insn[7:0]) &&
    zero_flag == (acc == 8'h00)) else $error("lxor");
  rxor_acc_a: assert property (rx && !d |=> acc == $past(r) &&
    zero_flag == (acc == 8'h00)) else $error("rxor acc");
  rxor_wb_a: assert property (rx && d |=> file_we &&
    file_wdata == $past(r) && $stable(acc)) else $error("rxor wb");
  zc_clr_a: assert property (zc && file_rdata != 8'h00 |=> !zero_flag &&
    !file_we && $stable(acc) && done) else $error("zc clr");
  idle_quiet_a: assert property (!(nb || rx || lx || zc) |=> !done &&
    !file_we && $stable(acc) && $stable(zero_flag)) else $error("idle");
endmodule : ops_props
bind nibble_swap_xor_test_ops ops_props u_ops_props (.*);

// *** tb/nibble_swap_xor_test_ops_bench.sv ***
// Bench for the operation unit
`timescale 1ns/1ps
module nibble_swap_xor_test_ops_bench;
  logic clk = 0, rst = 1, v = 0, we, z, dn;
  logic [13:0] insn = 0;
  logic [7:0] rd = 0, acc, wd;
  logic [6:0] fa;
  int n_fail = 0, checked = 0;
  nibble_swap_xor_test_ops u_nibble_swap_xor_test_ops (.clk(clk),
    .rst(rst), .insn_valid(v), .insn(insn), .file_rdata(rd),
    .file_addr(fa), .file_wdata(wd), .file_we(we), .acc(acc),
    .zero_flag(z), .done(dn));
  initial forever #20 clk = ~clk;
  task chk(string s, logic [7:0] g, logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Issue one instruction, check the outputs one cycle later
  task op(logic [13:0] i, logic [7:0] r, a, logic zz, w, logic [7:0] x);
    @(posedge clk) begin v <= 1; insn <= i; rd <= r; end
    @(posedge clk) v <= 0;
    #1;
    chk("acc", acc, a);
    chk("zero", {7'h00, z}, {7'h00, zz});
    chk("we", {7'h00, we}, {7'h00, w});
    chk("done", {7'h00, dn}, 8'h01);
    if (w) chk("wdata", wd, x);
    if (w) chk("addr", {1'b0, fa}, {1'b0, i[6:0]});
  endtask : op
  // Undecoded word: acc and zero hold, no write and no pulse comes
  task refused(logic [13:0] i, logic [7:0] a, logic zz);
    @(posedge clk) begin v <= 1; insn <= i; rd <= 8'h00; end
    @(posedge clk) v <= 0;
    #1;
    chk("acc", acc, a);
    chk("zero", {7'h00, z}, {7'h00, zz});
    chk("we", {7'h00, we}, 8'h00);
    chk("done", {7'h00, dn}, 8'h00);
  endtask : refused
  // Reset in mid-run brings every register back to its reset value
  task mid_reset;
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    #1;
    chk("acc", acc, 8'h00);
    chk("zero", {7'h00, z}, 8'h00);
    chk("we", {7'h00, we}, 8'h00);
    chk("done", {7'h00, dn}, 8'h00);
    chk("wdata", wd, 8'h00);
  endtask : mid_reset
  task print_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    op(14'h1F5A, 8'h00, 8'h5A, 0, 0, 8'h00);
    op(14'h1F5A, 8'h00, 8'h00, 1, 0, 8'h00);
    op(14'h0E85, 8'hA5, 8'h00, 1, 1, 8'h5A);
    op(14'h0E05, 8'hA5, 8'h5A, 1, 0, 8'h00);
    op(14'h0603, 8'hAF, 8'hF5, 0, 0, 8'h00);
    op(14'h0683, 8'hF5, 8'hF5, 1, 1, 8'h00);
    op(14'h0881, 8'h07, 8'hF5, 0, 0, 8'h00);
    op(14'h0881, 8'h00, 8'hF5, 1, 0, 8'h00);
    refused(14'h0801, 8'hF5, 1);
    refused(14'h3F5A, 8'hF5, 1);
    mid_reset();
    op(14'h1F5A, 8'h00, 8'h5A, 0, 0, 8'h00);
    print_verdict();
  end
endmodule : nibble_swap_xor_test_ops_bench
